// >>> logic/csc_ctrl.sv
// Single-conversion control and input range block behind an APB slave
`timescale 1ns/100ps
`default_nettype none
module csc_ctrl #(
	parameter int unsigned ADDR_W = 8
) (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Front end handshake
	input wire logic conv_done,
	input wire logic [1:0] result_valid,
	output csc_pkg::csc_conv_req_t conv_req,
	// Range selection to the front end
	output csc_pkg::csc_range_t range_sel,
	// Interrupt
	output logic irq
);
	// Byte addresses need at least the highest index times four
	if (ADDR_W < 5 || ADDR_W > 32) begin : g_chk
		$error("csc_ctrl: ADDR_W out of range");
	end

	// Byte address of a register index
	function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
		logic [31:0] full;
		full = 32'(idx) * csc_pkg::BYTE_PER_WORD;
		reg_addr = full[ADDR_W-1:0];
	endfunction

	// Whether an address hits a given register
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		hit = (a == reg_addr(idx));
	endfunction

	// Bus capture state
	logic cap_r, cap_nxt; // Request sampled, answer pending
	logic [31:0] rdata_r, rdata_nxt; // Read data from flops
	logic err_r, err_nxt; // Unmapped address seen
	logic done; // Access completes this edge
	logic wr_go; // Write takes effect this edge

	// Software-visible registers
	logic mode_r, mode_nxt; // Single-conversion mode enable
	logic [7:0] range_r, range_nxt; // Range register, reserved bits held zero
	logic [1:0] pwr_down_r, pwr_down_nxt; // Channel power-down controls

	// Decoded write strobes
	logic wr_one_shot; // One-shot register written
	logic wr_range; // Range register written
	logic wr_pwr; // Power-down written
	logic wr_clear; // Interrupt clear written
	logic wr_enable; // Interrupt enable written
	logic trig_wr; // Trigger bit written as one

	// Status from the sub-blocks
	logic busy; // Trigger bit as read back
	logic [1:0] irq_status; // Sticky data-ready flags
	logic [1:0] irq_enable; // Interrupt mask
	logic mapped; // Address decodes to a register
	logic [7:0] rd_byte; // Selected read value

	// Answer in the access phase once the request is captured
	assign done = psel && penable && cap_r && clk_en;
	assign wr_go = done && pwrite && !err_r;
	// Held low while frozen, so a master never completes an access the registers missed
	assign pready = psel && penable && cap_r && clk_en;
	assign pslverr = pready && err_r;
	assign prdata = rdata_r;

	// Address decode
	always_comb begin
		mapped = 1'b0;
		if (paddr[1:0] == 2'h0) begin
			mapped = hit(paddr, csc_pkg::IDX_ONE_SHOT) || hit(paddr, csc_pkg::IDX_RANGE)
				|| hit(paddr, csc_pkg::IDX_PWR_DOWN) || hit(paddr, csc_pkg::IDX_IRQ_STATUS)
				|| hit(paddr, csc_pkg::IDX_IRQ_CLEAR) || hit(paddr, csc_pkg::IDX_IRQ_ENABLE);
		end
	end

	// Read multiplexer; write-only clear reads zero
	always_comb begin
		rd_byte = 8'h00;
		if (hit(paddr, csc_pkg::IDX_ONE_SHOT)) begin
			// Reserved bits stay zero
			rd_byte[csc_pkg::TRIG_BIT] = busy;
			rd_byte[csc_pkg::MODE_BIT] = mode_r;
		end else if (hit(paddr, csc_pkg::IDX_RANGE)) begin
			rd_byte = range_r;
		end else if (hit(paddr, csc_pkg::IDX_PWR_DOWN)) begin
			rd_byte[1:0] = pwr_down_r;
		end else if (hit(paddr, csc_pkg::IDX_IRQ_STATUS)) begin
			rd_byte[1:0] = irq_status;
		end else if (hit(paddr, csc_pkg::IDX_IRQ_ENABLE)) begin
			rd_byte[1:0] = irq_enable;
		end else begin
			// Unmapped or write-only
			rd_byte = 8'h00;
		end
	end

	// Bus capture: sample once per transfer, release on completion
	always_comb begin
		cap_nxt = cap_r;
		rdata_nxt = rdata_r;
		err_nxt = err_r;
		if (done) begin
			// Transfer over, ready for the next setup
			cap_nxt = 1'b0;
		end else if (psel && !cap_r) begin
			// Setup seen; freeze the answer
			cap_nxt = 1'b1;
			err_nxt = !mapped;
			rdata_nxt = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
		end
	end

	// Bus capture registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			err_r <= 1'b0;
		end else if (clk_en) begin
			cap_r <= cap_nxt;
			rdata_r <= rdata_nxt;
			err_r <= err_nxt;
		end
	end

	// Write strobes, valid only at the completing edge
	assign wr_one_shot = wr_go && hit(paddr, csc_pkg::IDX_ONE_SHOT);
	assign wr_range = wr_go && hit(paddr, csc_pkg::IDX_RANGE);
	assign wr_pwr = wr_go && hit(paddr, csc_pkg::IDX_PWR_DOWN);
	assign wr_clear = wr_go && hit(paddr, csc_pkg::IDX_IRQ_CLEAR);
	assign wr_enable = wr_go && hit(paddr, csc_pkg::IDX_IRQ_ENABLE);
	// The sequencer decides whether a trigger counts
	assign trig_wr = wr_one_shot && pwdata[csc_pkg::TRIG_BIT];

	// Control register next values
	always_comb begin
		mode_nxt = mode_r;
		range_nxt = range_r;
		pwr_down_nxt = pwr_down_r;
		if (wr_one_shot) begin
			// Mode bit is plain read-write
			mode_nxt = pwdata[csc_pkg::MODE_BIT];
		end
		if (wr_range) begin
			// Reserved bits masked so they read zero
			range_nxt = pwdata[7:0] & csc_pkg::RANGE_MASK;
		end
		if (wr_pwr) begin
			pwr_down_nxt = pwdata[1:0];
		end
	end

	// Control registers, reset on every reset source
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r <= csc_pkg::ONE_SHOT_RESET[csc_pkg::MODE_BIT];
			range_r <= csc_pkg::RANGE_RESET;
			pwr_down_r <= csc_pkg::PWR_DOWN_RESET;
		end else if (clk_en) begin
			mode_r <= mode_nxt;
			range_r <= range_nxt;
			pwr_down_r <= pwr_down_nxt;
		end
	end

	// Range fields straight from the flops
	assign range_sel.chan_one_range_field =
		range_r[csc_pkg::RANGE_ONE_LSB +: csc_pkg::RANGE_W];
	assign range_sel.chan_two_range_field =
		range_r[csc_pkg::RANGE_TWO_LSB +: csc_pkg::RANGE_W];

	// Trigger sequencer; ignores writes while busy
	csc_trig u_trig (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.trig_wr(trig_wr),
		.mode_en(mode_r),
		.pwr_down(pwr_down_r),
		.conv_done(conv_done),
		.conv_req(conv_req),
		.busy(busy)
	);

	// Data-ready flags and interrupt; clear is write-one
	csc_irq #(
		.NCH(csc_pkg::NCHAN)
	) u_irq (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.event_set(result_valid),
		.clear_bits(pwdata[1:0]),
		.clear_wr(wr_clear),
		.enable_bits(pwdata[1:0]),
		.enable_wr(wr_enable),
		.status(irq_status),
		.enable(irq_enable),
		.irq(irq)
	);
endmodule
`default_nettype wire

// >>> logic/csc_pkg.sv
// Package: register map, field layout, reset values and carrier types
package csc_pkg;
	// Register indices; the byte address is four times the index
	localparam logic [7:0] IDX_ONE_SHOT = 8'h01;
	localparam logic [7:0] IDX_RANGE = 8'h02;
	localparam logic [7:0] IDX_PWR_DOWN = 8'h03;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h04;
	localparam logic [7:0] IDX_IRQ_CLEAR = 8'h05;
	localparam logic [7:0] IDX_IRQ_ENABLE = 8'h06;
	localparam int unsigned BYTE_PER_WORD = 4;

	// One-shot register fields
	localparam int unsigned TRIG_BIT = 0;
	localparam int unsigned MODE_BIT = 1;
	localparam logic [7:0] ONE_SHOT_RESET = 8'h00;

	// Range register fields and reset value
	localparam int unsigned RANGE_ONE_LSB = 0;
	localparam int unsigned RANGE_TWO_LSB = 4;
	localparam int unsigned RANGE_W = 2;
	localparam logic [7:0] RANGE_RESET = 8'h22;
	localparam logic [7:0] RANGE_MASK = 8'h33;

	// Power-down and interrupt registers
	localparam logic [1:0] PWR_DOWN_RESET = 2'h0;
	localparam logic [1:0] IRQ_RESET = 2'h0;
	localparam int unsigned NCHAN = 2;

	// Range codes
	typedef enum logic [1:0] {
		CSC_RANGE_5PF = 2'h0,
		CSC_RANGE_10PF = 2'h1,
		CSC_RANGE_20PF = 2'h2,
		CSC_RANGE_20PF_ALT = 2'h3
	} csc_range_code_t;

	// Range selection for both channels
	typedef struct packed {
		logic [1:0] chan_two_range_field;
		logic [1:0] chan_one_range_field;
	} csc_range_t;

	// Conversion request towards the front end
	typedef struct packed {
		logic start;
		logic [1:0] chan_en;
	} csc_conv_req_t;
endpackage

// >>> logic/csc_irq.sv
// Sticky data-ready status with clear, enable and interrupt output
`timescale 1ns/100ps
`default_nettype none
module csc_irq #(
	parameter int unsigned NCH = 2
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// Events and software controls
	input wire logic [NCH-1:0] event_set,
	input wire logic [NCH-1:0] clear_bits,
	input wire logic clear_wr,
	input wire logic [NCH-1:0] enable_bits,
	input wire logic enable_wr,
	// Results
	output logic [NCH-1:0] status,
	output logic [NCH-1:0] enable,
	output logic irq
);
	// Refuse widths the map cannot hold
	if (NCH < 1 || NCH > 8) begin : g_chk
		$error("csc_irq: NCH out of range");
	end

	logic [NCH-1:0] status_r, status_nxt; // Sticky flags
	logic [NCH-1:0] enable_r, enable_nxt; // Mask

	// Set wins over a clear landing in the same cycle
	always_comb begin
		status_nxt = status_r;
		enable_nxt = enable_r;
		if (clear_wr) begin
			status_nxt = status_nxt & ~clear_bits;
		end
		status_nxt = status_nxt | event_set;
		if (enable_wr) begin
			enable_nxt = enable_bits;
		end
	end

	// Registers, frozen while the clock enable is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r <= NCH'(csc_pkg::IRQ_RESET);
			enable_r <= NCH'(csc_pkg::IRQ_RESET);
		end else if (clk_en) begin
			status_r <= status_nxt;
			enable_r <= enable_nxt;
		end
	end

	assign status = status_r;
	assign enable = enable_r;
	// Level interrupt while any enabled flag stands
	assign irq = |(status_r & enable_r);
endmodule
`default_nettype wire

// >>> logic/csc_trig.sv
// One-shot trigger sequencer: start, busy and self-clear
`timescale 1ns/100ps
`default_nettype none
module csc_trig (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// Software side
	input wire logic trig_wr,
	input wire logic mode_en,
	input wire logic [1:0] pwr_down,
	// Front end side
	input wire logic conv_done,
	output csc_pkg::csc_conv_req_t conv_req,
	output logic busy
);
	typedef enum logic {CSC_IDLE, CSC_BUSY} csc_trig_state_t;

	csc_trig_state_t state_r, state_nxt; // Sequencer state
	csc_pkg::csc_conv_req_t req_r, req_nxt; // Registered request

	// Next state; a write while busy is simply not looked at
	always_comb begin
		state_nxt = state_r;
		req_nxt = req_r;
		req_nxt.start = 1'b0;
		case (state_r)
			CSC_IDLE: begin
				// Needs mode on and at least one powered channel
				if (trig_wr && mode_en && (pwr_down != 2'h3)) begin
					state_nxt = CSC_BUSY;
					req_nxt.start = 1'b1;
					req_nxt.chan_en = ~pwr_down;
				end
			end
			CSC_BUSY: begin
				// Only the end of conversion releases the bit
				if (conv_done) begin
					state_nxt = CSC_IDLE;
					req_nxt.chan_en = 2'h0;
				end
			end
			default: begin
				state_nxt = CSC_IDLE;
			end
		endcase
	end

	// State registers, cleared on reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= CSC_IDLE;
			req_r <= '0;
		end else if (clk_en) begin
			state_r <= state_nxt;
			req_r <= req_nxt;
		end
	end

	assign conv_req = req_r;
	assign busy = (state_r == CSC_BUSY);
endmodule
`default_nettype wire

// >>> sim/csc_fe_model.sv
// Front end model: delayed done and result pulses
`timescale 1ns/100ps
`default_nettype none
module csc_fe_model #(
	parameter int DLY = 30
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Request in, results out
	input wire csc_pkg::csc_conv_req_t conv_req,
	output logic conv_done,
	output logic [1:0] result_valid
);
	int cnt; // Cycles left, 0 when idle
	logic [1:0] en_r; // Channels latched at start
	// Slow answer so the busy window is wide enough to poke at
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			en_r <= 2'h0;
			conv_done <= 1'b0;
			result_valid <= 2'h0;
		end else begin
			conv_done <= (cnt == 1);
			result_valid <= (cnt == 1) ? en_r : 2'h0;
			if (conv_req.start) begin
				cnt <= DLY;
				en_r <= conv_req.chan_en;
			end else if (cnt != 0) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> sim/csc_ctrl_props.sv
// Checker for the one-shot and range registers at the top ports
`timescale 1ns/100ps
`default_nettype none
module csc_ctrl_props #(
	parameter int unsigned ADDR_W = 8
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	// Front end
	input wire logic conv_done,
	input wire csc_pkg::csc_conv_req_t conv_req,
	input wire csc_pkg::csc_range_t range_sel
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Completed access at one address
	sequence s_acc(logic [ADDR_W-1:0] a, logic w);
		psel && penable && pready && pwrite == w && paddr == a;
	endsequence
	a_trig_rsvd: assert property (s_acc(8'h04, 1'b0) |-> prdata[7:2] == 6'h00)
		else $error("one-shot reserved bits set");
	a_range_reset: assert property ($rose(presetn) |-> range_sel == 4'hA)
		else $error("range reset value wrong");
	a_start_cause: assert property (conv_req.start |-> $past(psel && penable && pwrite && paddr == 8'h04 && pwdata[0]))
		else $error("start without trigger write");
	a_start_chan: assert property (conv_req.start |-> conv_req.chan_en != 2'h0)
		else $error("start with no channel");
	a_start_once: assert property (conv_req.start |=> !conv_req.start [*8])
		else $error("restart while busy");
	a_busy_hold: assert property (conv_req.chan_en != 2'h0 && !conv_done |=> $stable(conv_req.chan_en))
		else $error("channels dropped early");
	a_done_idle: assert property (conv_req.chan_en != 2'h0 && conv_done |=> conv_req.chan_en == 2'h0)
		else $error("busy after done");
	a_range_wr: assert property (s_acc(8'h08, 1'b1) |=> range_sel == $past({pwdata[5:4], pwdata[1:0]}))
		else $error("range write not applied");
	a_range_keep: assert property (!(psel && penable && pready && pwrite && paddr == 8'h08) |=> $stable(range_sel))
		else $error("range changed without write");
	a_range_rd: assert property (s_acc(8'h08, 1'b0) |-> prdata[7:0] == {2'h0, range_sel[3:2], 2'h0, range_sel[1:0]})
		else $error("range read mismatch");
endmodule
bind csc_ctrl csc_ctrl_props #(.ADDR_W(ADDR_W)) i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .conv_done(conv_done), .conv_req(conv_req), .range_sel(range_sel));
`default_nettype wire

// >>> sim/cap_sense_single_conv_ctrl_bench.sv
// Bench: APB master, reference model and scenarios
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin failures++; $display("BAD %s exp %0h got %0h", n, e, s); end end
module cap_sense_single_conv_ctrl_bench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, conv_done, irq, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, v;
	logic [1:0] result_valid;
	csc_pkg::csc_conv_req_t conv_req;
	csc_pkg::csc_range_t range_sel;
	int failures = 0;
	int num_checks = 0;
	int m_st = 0; // Model sticky status
	logic [31:0] seed = 32'h4DAA7B79;
	// Design; clock enable held on so no state freezes
	csc_ctrl i_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .conv_done(conv_done), .result_valid(result_valid),
		.conv_req(conv_req), .range_sel(range_sel), .irq(irq));
	csc_fe_model i_fe (.pclk(pclk), .presetn(presetn), .conv_req(conv_req),
		.conv_done(conv_done), .result_valid(result_valid));
	// Xorshift source
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Verdict and end of run
	task automatic final_report();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// One APB transfer; request held until pready is high at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// Sampled at the rising edge, before the design's flops move
		while (pready !== 1'b1) begin
			n++;
			if (n > 20) begin
				failures++;
				final_report();
			end
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Read and compare with the model
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, xs());
		`CHK($sformatf("reg %0h", a), e, rd)
	endtask
	// Bounded wait for the conversion to end
	task automatic wait_idle();
		int n;
		n = 0;
		@(negedge pclk);
		while (conv_req.chan_en !== 2'h0) begin
			n++;
			if (n > 100) begin
				failures++;
				final_report();
			end
			@(negedge pclk);
		end
	endtask
	// Clock
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// Main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rchk(8'h04, 32'h00);
		rchk(8'h08, 32'h22);
		// Every range code on both channels, junk in reserved bits
		for (int i = 0; i < 4; i++) begin
			v = (xs() & 32'hFFFFFFCC) | (i << 4) | (3 - i);
			apb(1'b1, 8'h08, v);
			@(negedge pclk);
			`CHK("range_sel", {v[5:4], v[1:0]}, range_sel)
			rchk(8'h08, v & 32'h33);
		end
		apb(1'b1, 8'h04, 32'h1);
		rchk(8'h04, 32'h00);
		apb(1'b1, 8'h04, (xs() & 32'hFFFFFFFC) | 32'h2);
		rchk(8'h04, 32'h02);
		// Each power-down pattern: start (refused when both channels are down), cancel attempt, self-clear
		for (int p = 0; p < 4; p++) begin
			apb(1'b1, 8'h0C, p);
			apb(1'b1, 8'h04, 32'h3);
			rchk(8'h04, (p == 3) ? 32'h2 : 32'h3);
			`CHK("chan_en", (p == 3) ? 2'h0 : 2'(~p), conv_req.chan_en)
			apb(1'b1, 8'h04, 32'h2);
			rchk(8'h04, (p == 3) ? 32'h2 : 32'h3);
			wait_idle();
			rchk(8'h04, 32'h2);
			if (p != 3) m_st = m_st | (~p & 3);
			rchk(8'h10, m_st);
		end
		apb(1'b1, 8'h18, 32'h2);
		@(negedge pclk);
		`CHK("irq on", 1'b1, irq)
		apb(1'b1, 8'h14, 32'h2);
		m_st = m_st & 1;
		rchk(8'h10, m_st);
		`CHK("irq off", 1'b0, irq)
		rchk(8'h14, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		`CHK("unmapped err", 1'b1, err)
		// Reset in mid-run
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rchk(8'h08, 32'h22);
		rchk(8'h04, 32'h00);
		final_report();
	end
endmodule
`default_nettype wire
